// File: src/tbp_pkg.sv
// constants for the pwm time-base prescale, sync and period load block
`default_nettype none
package tbp_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  // register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h02;
  localparam logic [7:0] ADDR_PHASE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  // timebase_control field positions
  localparam int BASE_SEL_LSB = 10;
  localparam int FAST_SEL_LSB = 7;
  localparam int SOFT_SYNC_BIT = 6;
  localparam int SYNC_SEL_LSB = 4;
  localparam int PRD_MODE_BIT = 3;
  localparam int PHASE_EN_BIT = 2;
  // reset values
  localparam logic [2:0] FAST_SEL_RST = 3'h1;
  localparam logic [2:0] BASE_SEL_RST = 3'h0;
  localparam logic [1:0] SYNC_SEL_RST = 2'h0;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  // sync output selector codes
  typedef enum logic [1:0] {
    TBP_SO_PASS = 2'h0,
    TBP_SO_ZERO = 2'h1,
    TBP_SO_COMP_B = 2'h2,
    TBP_SO_OFF = 2'h3
  } tbp_sync_sel_e;
  // widest combined divisor is 14 * 128
  localparam int DIV_W = 11;
endpackage : tbp_pkg
`default_nettype wire

// File: src/tbp_presc_if.sv
// prescaler selection and tick carried between top and divider
`default_nettype none
interface tbp_presc_if;
  logic [2:0] fast_sel;
  logic [2:0] base_sel;
  logic tick;
  modport ctrl (output fast_sel, output base_sel, input tick);
  modport div (input fast_sel, input base_sel, output tick);
endinterface : tbp_presc_if
`default_nettype wire

// File: src/tbp_prescaler.sv
// two-stage prescaler making the time-base clock enable
`default_nettype none
module tbp_prescaler (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset, high
  input wire logic ce, // clock enable
  tbp_presc_if.div pif // selections in, tick out
);
  logic [tbp_pkg::DIV_W-1:0] fast_div;
  logic [tbp_pkg::DIV_W-1:0] base_div;
  logic [tbp_pkg::DIV_W-1:0] total_div;
  logic [tbp_pkg::DIV_W-1:0] cnt_reg;

  // fast stage is 1 or twice the code, base stage a power of two
  always_comb
  begin
    fast_div = (pif.fast_sel == 3'h0) ? 11'h001 : {7'h00, pif.fast_sel, 1'b0};
    base_div = 11'h001 << pif.base_sel;
    total_div = 11'(fast_div * base_div);
  end

  // one counter across the product; a selection change restarts cleanly at wrap
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= (cnt_reg >= total_div - 11'h001) ? '0 : cnt_reg + 11'h001;
  end

  assign pif.tick = ce && (cnt_reg >= total_div - 11'h001);

  fast_table_a: assert property (@(posedge clk_sys) disable iff (srst)
    pif.fast_sel == 3'h3 |-> fast_div == 11'h006) else $error("fast divisor code 3 not /6");
  base_table_a: assert property (@(posedge clk_sys) disable iff (srst)
    pif.base_sel == 3'h7 |-> base_div == 11'h080) else $error("base divisor code 7 not /128");
  // a selection write between ticks legally changes the spacing, so the selection must hold throughout
  tick_spacing_a: assert property (@(posedge clk_sys) disable iff (srst)
    pif.tick && ce && pif.fast_sel == 3'h1 && pif.base_sel == 3'h0
    ##1 ce && pif.fast_sel == 3'h1 && pif.base_sel == 3'h0
    |-> !pif.tick ##1 (pif.tick || !ce || pif.fast_sel != 3'h1 || pif.base_sel != 3'h0))
    else $error("divide by two tick spacing wrong");
  div14_c: cover property (@(posedge clk_sys) pif.fast_sel == 3'h7 && pif.tick);
endmodule : tbp_prescaler
`default_nettype wire

// File: src/tbp_period.sv
// period value with shadow and active copies
`default_nettype none
module tbp_period (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic wr, // software write to period
  input wire logic [15:0] wdata, // written value
  input wire logic load_mode, // 0 shadowed, 1 immediate
  input wire logic ctr_zero, // counter equals zero
  output logic [15:0] read_value, // value software reads
  output logic [15:0] active_value // period used by counter
);
  logic [15:0] shadow_reg;
  logic [15:0] active_reg;

  // shadow takes every write so a later mode switch starts consistent
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      shadow_reg <= tbp_pkg::PERIOD_RST;
    else if (ce && wr)
      shadow_reg <= wdata;
  end

  // active copy: immediate write, or transfer at counter zero
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      active_reg <= tbp_pkg::PERIOD_RST;
    else if (ce && wr && load_mode)
      active_reg <= wdata;
    else if (ce && !load_mode && ctr_zero)
      active_reg <= shadow_reg;
  end

  assign read_value = load_mode ? active_reg : shadow_reg;
  assign active_value = active_reg;

  shadow_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && !load_mode && ctr_zero |=> active_reg == $past(shadow_reg)) else $error("shadow not loaded at zero");
  shadow_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && wr && !load_mode && !ctr_zero |=> active_reg == $past(active_reg)) else $error("shadowed write hit active");
  immediate_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && wr && load_mode |=> active_reg == $past(wdata)) else $error("immediate write not applied");
  zero_load_c: cover property (@(posedge clk_sys) ce && !load_mode && ctr_zero && shadow_reg != active_reg);
endmodule : tbp_period
`default_nettype wire

// File: src/tbp_top.sv
// pwm time-base prescale, sync select and period load control
`default_nettype none
// Overview of operation
// - time-base tick rate is system clock over fast times base divisor
// - fast divisor codes give /1 /2 /4 /6 /8 /10 /12 /14
// - fast divisor field resets to the divide-by-two code
// - writing one to the soft sync bit makes one sync pulse
// - writing zero there does nothing; the bit always reads zero
// - soft pulse and sync input are ORed into one sync event
// - soft pulse only acts while sync output selects pass-through
// - sync output: 00 pass, 01 counter zero, 10 compare b, 11 off
// - shadow mode copies shadow to active period at counter zero
// - shadow mode reads and writes of period reach the shadow
// - immediate mode reads and writes act on the active period
// - base divisor codes give /1 to /128, reset to /1
// - with phase load on, each sync event loads counter from phase
module tbp_top (
  input wire logic clk_sys, // system clock, 50 MHz
  input wire logic srst, // sync reset, high
  input wire logic ce, // clock enable, freezes all state
  input wire logic [7:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic [15:0] timebase_count, // counter value from counter
  input wire logic compare_b_match, // counter equals compare b
  input wire logic sync_in, // sync from previous module
  output logic sync_out, // sync to next module
  output logic tb_tick, // time-base clock enable
  output logic sync_event, // one-cycle sync to counter
  output logic phase_load, // load counter from phase
  output logic [15:0] phase_value, // phase for counter load
  output logic [15:0] period_active // active period for counter
);
  tbp_presc_if pif ();

  logic [2:0] fast_sel_reg;
  logic [2:0] base_sel_reg;
  logic [1:0] sync_sel_reg;
  logic prd_mode_reg;
  logic phase_en_reg;
  logic [15:0] phase_reg;
  logic soft_pulse_reg;
  logic sync_in_d_reg;
  logic sync_event_reg;
  logic sync_out_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] prd_read;
  logic wr_ctrl;
  logic wr_prd;
  logic wr_phase;
  logic ctr_zero;
  logic in_edge;
  logic sync_raw;

  // address decode, strobes qualified by the clock enable
  assign wr_ctrl = ce && reg_wr && reg_addr == tbp_pkg::ADDR_CTRL;
  assign wr_prd = ce && reg_wr && reg_addr == tbp_pkg::ADDR_PERIOD;
  assign wr_phase = ce && reg_wr && reg_addr == tbp_pkg::ADDR_PHASE;
  assign ctr_zero = timebase_count == 16'h0000;

  // control fields; reset puts the fast stage at /2 and base at /1
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      fast_sel_reg <= tbp_pkg::FAST_SEL_RST;
      base_sel_reg <= tbp_pkg::BASE_SEL_RST;
      sync_sel_reg <= tbp_pkg::SYNC_SEL_RST;
      prd_mode_reg <= 1'b0;
      phase_en_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      fast_sel_reg <= reg_wdata[tbp_pkg::FAST_SEL_LSB +: 3];
      base_sel_reg <= reg_wdata[tbp_pkg::BASE_SEL_LSB +: 3];
      sync_sel_reg <= reg_wdata[tbp_pkg::SYNC_SEL_LSB +: 2];
      prd_mode_reg <= reg_wdata[tbp_pkg::PRD_MODE_BIT];
      phase_en_reg <= reg_wdata[tbp_pkg::PHASE_EN_BIT];
    end
  end

  // phase value register
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      phase_reg <= tbp_pkg::PHASE_RST;
    else if (wr_phase)
      phase_reg <= reg_wdata;
  end

  // soft sync is a strobe, never stored; the gate uses the select in force at the write
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      soft_pulse_reg <= 1'b0;
    else if (ce)
      soft_pulse_reg <= wr_ctrl && reg_wdata[tbp_pkg::SOFT_SYNC_BIT]
        && sync_sel_reg == tbp_pkg::TBP_SO_PASS;
  end

  // a held sync input would otherwise reload the counter every cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sync_in_d_reg <= 1'b0;
    else if (ce)
      sync_in_d_reg <= sync_in;
  end

  assign in_edge = sync_in && !sync_in_d_reg;
  assign sync_raw = in_edge || soft_pulse_reg;

  // registered sync event, one cycle per source edge or soft write
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sync_event_reg <= 1'b0;
    else if (ce)
      sync_event_reg <= sync_raw;
  end

  // sync output selector
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sync_out_reg <= 1'b0;
    else if (ce)
    begin
      unique case (tbp_pkg::tbp_sync_sel_e'(sync_sel_reg))
        tbp_pkg::TBP_SO_PASS: sync_out_reg <= sync_raw;
        tbp_pkg::TBP_SO_ZERO: sync_out_reg <= ctr_zero;
        tbp_pkg::TBP_SO_COMP_B: sync_out_reg <= compare_b_match;
        tbp_pkg::TBP_SO_OFF: sync_out_reg <= 1'b0;
      endcase
    end
  end

  assign pif.fast_sel = fast_sel_reg;
  assign pif.base_sel = base_sel_reg;

  tbp_prescaler u_presc (
    .clk_sys (clk_sys),
    .srst (srst),
    .ce (ce),
    .pif (pif)
  );

  tbp_period u_period (
    .clk_sys (clk_sys),
    .srst (srst),
    .ce (ce),
    .wr (wr_prd),
    .wdata (reg_wdata),
    .load_mode (prd_mode_reg),
    .ctr_zero (ctr_zero),
    .read_value (prd_read),
    .active_value (period_active)
  );

  // read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    rdata_next = 16'h0000;
    unique case (reg_addr)
      tbp_pkg::ADDR_CTRL:
      begin
        rdata_next[tbp_pkg::BASE_SEL_LSB +: 3] = base_sel_reg;
        rdata_next[tbp_pkg::FAST_SEL_LSB +: 3] = fast_sel_reg;
        rdata_next[tbp_pkg::SOFT_SYNC_BIT] = 1'b0;
        rdata_next[tbp_pkg::SYNC_SEL_LSB +: 2] = sync_sel_reg;
        rdata_next[tbp_pkg::PRD_MODE_BIT] = prd_mode_reg;
        rdata_next[tbp_pkg::PHASE_EN_BIT] = phase_en_reg;
      end
      tbp_pkg::ADDR_PERIOD: rdata_next = prd_read;
      tbp_pkg::ADDR_PHASE: rdata_next = phase_reg;
      tbp_pkg::ADDR_STATUS: rdata_next = timebase_count;
      default: rdata_next = 16'h0000;
    endcase
  end

  // read data stands one cycle after the strobe and reads zero otherwise
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata_reg <= 16'h0000;
    else if (ce)
      rdata_reg <= reg_rd ? rdata_next : 16'h0000;
  end

  assign reg_rdata = rdata_reg;
  assign sync_out = sync_out_reg;
  assign tb_tick = pif.tick;
  assign sync_event = sync_event_reg;
  assign phase_load = sync_event_reg && phase_en_reg;
  assign phase_value = phase_reg;

  fast_reset_a: assert property (@(posedge clk_sys)
    $past(srst) && !srst |-> fast_sel_reg == 3'h1 && base_sel_reg == 3'h0) else $error("reset divisors wrong");
  soft_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
    wr_ctrl && reg_wdata[6] && sync_sel_reg == 2'h0 ##1 ce |=> sync_event) else $error("soft sync lost");
  soft_read_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && reg_rd && reg_addr == 8'h00 |=> reg_rdata[6] == 1'b0) else $error("soft sync bit read nonzero");
  sync_or_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && sync_in && !sync_in_d_reg |=> sync_event) else $error("input sync not passed");
  soft_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && !sync_in && wr_ctrl && sync_sel_reg != 2'h0 && !soft_pulse_reg ##1 ce && !in_edge |=> !sync_event)
    else $error("soft sync acted while not pass-through");
  out_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && sync_sel_reg == 2'h1 && !wr_ctrl |=> sync_out == $past(ctr_zero)) else $error("sync out zero select wrong");
  out_off_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && sync_sel_reg == 2'h3 |=> !sync_out) else $error("disabled sync out active");
  phase_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && sync_raw && phase_en_reg && !wr_ctrl |=> phase_load) else $error("phase load missed");
  single_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
    ce && sync_in && sync_in_d_reg ##1 ce && !soft_pulse_reg |=> !sync_event) else $error("held sync in repeated");
  soft_sync_c: cover property (@(posedge clk_sys) soft_pulse_reg && ce ##1 sync_event && sync_out);
  comp_b_out_c: cover property (@(posedge clk_sys) sync_sel_reg == 2'h2 && compare_b_match ##1 sync_out);
endmodule : tbp_top
`default_nettype wire

// File: testbench/tbp_nbr.sv
// neighbour model: upstream sync source and the time-base counter
`default_nettype none
module tbp_nbr #(
  parameter logic [15:0] WRAP = 16'h0003,
  parameter logic [15:0] COMP_B = 16'h0002
) (
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset, high
  input wire logic tick, // time-base enable
  input wire logic fire, // request one sync
  output logic sync_in, // sync to the block
  output logic [15:0] count, // counter value
  output logic compare_b_match // count equals compare b
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] hold_reg;
  // sync held three cycles so only its edge may count
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      hold_reg <= 2'h0;
    else if (fire)
      hold_reg <= 2'h3;
    else if (hold_reg != 2'h0)
      hold_reg <= hold_reg - 2'h1;
  end
  assign sync_in = (hold_reg != 2'h0);
  // counter wraps short so zero comes often
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      count <= 16'h0000;
    else if (tick)
      count <= (count == WRAP) ? 16'h0000 : count + 16'h0001;
  end
  assign compare_b_match = (count == COMP_B);
endmodule : tbp_nbr
`default_nettype wire

// File: testbench/test_pwm_timebase_prescale_sync_period_load.sv
// self-checking bench for the time-base prescale, sync and period block
`default_nettype none
module test_pwm_timebase_prescale_sync_period_load;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, srst, reg_wr, reg_rd, fire, compare_b_match, sync_in, sync_out, tb_tick, sync_event, phase_load;
  logic ce;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, count, phase_value, period_active;
  int n_fail, n_compared, n_ev, n_so, n_pl;
  tbp_top dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timebase_count(count),
    .compare_b_match(compare_b_match), .sync_in(sync_in), .sync_out(sync_out), .tb_tick(tb_tick),
    .sync_event(sync_event), .phase_load(phase_load), .phase_value(phase_value), .period_active(period_active));
  tbp_nbr nbr (.clk_sys(clk_sys), .srst(srst), .tick(tb_tick), .fire(fire), .sync_in(sync_in),
    .count(count), .compare_b_match(compare_b_match));
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge clk_sys)
  begin
    if (sync_event === 1'b1) n_ev++;
    if (sync_out === 1'b1) n_so++;
    if (phase_load === 1'b1) n_pl++;
  end
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
  endtask : rd
  task clr;
    n_ev = 0;
    n_so = 0;
    n_pl = 0;
  endtask : clr
  task wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    do begin @(negedge clk_sys); n++; end while (count !== v && n < 9000);
  endtask : wait_cnt
  task t_reset;
    rd(tbp_pkg::ADDR_CTRL);
    check("ctrl reset", reg_rdata, 16'h0080);
    rd(tbp_pkg::ADDR_PERIOD);
    check("period reset", reg_rdata, 16'h0000);
    rd(8'h0e);
    check("unmapped read", reg_rdata, 16'h0000);
    wr(tbp_pkg::ADDR_PHASE, 16'h5a5a);
    @(negedge clk_sys);
    check("phase value out", phase_value, 16'h5a5a);
    rd(tbp_pkg::ADDR_PHASE);
    check("phase read", reg_rdata, 16'h5a5a);
    $display("t_reset done");
  endtask : t_reset
  task measure(input logic [15:0] ctrl, input int exp);
    int n;
    wr(tbp_pkg::ADDR_CTRL, ctrl);
    repeat (2) do @(negedge clk_sys); while (tb_tick !== 1'b1);
    n = 0;
    do begin @(negedge clk_sys); n++; end while (tb_tick !== 1'b1 && n < 4000);
    check("tick spacing", 16'(n), 16'(exp));
  endtask : measure
  task t_presc;
    for (int c = 0; c < 8; c++)
      measure(16'(c) << tbp_pkg::FAST_SEL_LSB, (c == 0) ? 1 : 2 * c);
    for (int c = 0; c < 8; c++)
      measure((16'(c) << tbp_pkg::BASE_SEL_LSB) | 16'h0080, 2 << c);
    $display("t_presc done");
  endtask : t_presc
  task t_soft;
    clr();
    wr(tbp_pkg::ADDR_CTRL, 16'h00c4);
    repeat (6) @(negedge clk_sys);
    check("soft events", 16'(n_ev), 16'h0001);
    check("soft sync out", 16'(n_so), 16'h0001);
    check("soft phase load", 16'(n_pl), 16'h0001);
    rd(tbp_pkg::ADDR_CTRL);
    check("soft bit reads", reg_rdata, 16'h0084);
    clr();
    wr(tbp_pkg::ADDR_CTRL, 16'h0084);
    // the gate looks at the select already in force, so switch the output off first
    wr(tbp_pkg::ADDR_CTRL, 16'h00b4);
    wr(tbp_pkg::ADDR_CTRL, 16'h00f4);
    repeat (6) @(negedge clk_sys);
    check("gated soft events", 16'(n_ev), 16'h0000);
    $display("t_soft done");
  endtask : t_soft
  // held input sync must give one event only
  task t_sync_in(input logic [15:0] ctrl, input logic [15:0] exp_so);
    wr(tbp_pkg::ADDR_CTRL, ctrl);
    clr();
    @(posedge clk_sys);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (8) @(negedge clk_sys);
    check("input events", 16'(n_ev), 16'h0001);
    check("input sync out", 16'(n_so), exp_so);
    check("input phase load", 16'(n_pl), 16'h0001);
    $display("t_sync_in done");
  endtask : t_sync_in
  task t_sync_sel;
    logic prev;
    for (int s = 1; s < 4; s++)
    begin
      wr(tbp_pkg::ADDR_CTRL, 16'(s) << tbp_pkg::SYNC_SEL_LSB);
      @(negedge clk_sys);
      prev = (s == 1) ? (count == 16'h0000) : (s == 2) ? compare_b_match : 1'b0;
      repeat (12)
      begin
        @(negedge clk_sys);
        check("sync out select", {15'h0000, sync_out}, {15'h0000, prev});
        prev = (s == 1) ? (count == 16'h0000) : (s == 2) ? compare_b_match : 1'b0;
      end
    end
    $display("t_sync_sel done");
  endtask : t_sync_sel
  task t_period;
    wr(tbp_pkg::ADDR_CTRL, 16'h1f80);
    wait_cnt(16'h0001);
    wr(tbp_pkg::ADDR_PERIOD, 16'h1234);
    rd(tbp_pkg::ADDR_PERIOD);
    check("shadow read", reg_rdata, 16'h1234);
    check("active held", period_active, 16'h0000);
    wait_cnt(16'h0000);
    @(negedge clk_sys);
    check("active at zero", period_active, 16'h1234);
    rd(tbp_pkg::ADDR_STATUS);
    check("status read", reg_rdata, 16'h0000);
    wr(tbp_pkg::ADDR_CTRL, 16'h0088);
    wr(tbp_pkg::ADDR_PERIOD, 16'h00ab);
    @(negedge clk_sys);
    check("active direct", period_active, 16'h00ab);
    rd(tbp_pkg::ADDR_PERIOD);
    check("direct read", reg_rdata, 16'h00ab);
    $display("t_period done");
  endtask : t_period
  // a control write strobe with the clock enable low must leave the control register alone and make no soft sync
  task t_freeze;
    @(posedge clk_sys);
    ce <= 1'b0;
    clr();
    wr(tbp_pkg::ADDR_CTRL, 16'h0040);
    ce <= 1'b1;
    repeat (4) @(negedge clk_sys);
    check("frozen soft events", 16'(n_ev), 16'h0000);
    rd(tbp_pkg::ADDR_CTRL);
    check("frozen ctrl", reg_rdata, 16'h0084);
    $display("t_freeze done");
  endtask : t_freeze
  // run span is about seven to thirteen thousand cycles, mostly the /1792 period waits; the limit leaves wide margin
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    $display("ERROR watchdog expected done seen hang");
    end_of_test();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fire = 1'b0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_presc();
    t_soft();
    t_sync_in(16'h0084, 16'h0001);
    t_freeze();
    t_sync_in(16'h00b4, 16'h0000);
    t_sync_sel();
    t_period();
    end_of_test();
  end
endmodule : test_pwm_timebase_prescale_sync_period_load
`default_nettype wire
